// >>> src/fpx_exception_unit.v
// Floating-point exception unit: detects the five exception classes for one
// completing operation, picks the target register value, and keeps the
// status and control register and the handler mode bits behind an APB slave.
// Assumes the rounding datapath presents its intermediate results in the same
// cycle as I_OP_VALID, and that all inputs are synchronous to I_REF_CLK.
//
// The implementer's own choices: the APB slave port and the register offsets.
`include "fpx_defs.vh"

module fpx_exception_unit #(
    parameter AW = 12
) (
    input wire I_REF_CLK,
    input wire I_RST,
    // APB slave
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [AW-1:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output wire O_PREADY,
    output wire O_PSLVERR,
    // Operation completing in the pipeline
    input wire I_OP_VALID,
    input wire [3:0] I_OP_CODE,
    input wire I_OP_SP,
    input wire [2:0] I_A_CLASS,
    input wire I_A_SIGN,
    input wire [2:0] I_B_CLASS,
    input wire I_B_SIGN,
    input wire I_CVT_BIG,
    // Rounding datapath results
    input wire [13:0] I_PRE_EXP,
    input wire I_PRE_ZERO,
    input wire I_RND_SIGN,
    input wire [13:0] I_RND_EXP,
    input wire [51:0] I_RND_FRAC,
    input wire I_RND_ZERO,
    input wire I_RND_INC,
    input wire I_RND_INX,
    input wire I_RND_SIGDIFF,
    input wire I_PASS,
    input wire [63:0] I_ALT_RESULT,
    input wire I_DEN_INC,
    input wire I_DEN_LOSS,
    input wire [63:0] I_CVT_RESULT,
    input wire [3:0] I_CMP_CC,
    // Results toward completion
    output reg O_DONE,
    output reg O_RES_WE,
    output reg [63:0] O_RES_DATA,
    output reg O_TRAP
);

    // Status and control register and handler mode bits
    reg [31:0] st_q;
    reg [1:0] mode_q;

    // Build a double-format word from sign, unbiased exponent and fraction
    function [63:0] pack;
        input sgn;
        input [13:0] ex;
        input [51:0] fr;
        reg [13:0] b;
        begin
            b = ex + `FPX_BIAS;
            pack = {sgn, b[10:0], fr};
        end
    endfunction

    // Class and sign of a double-format word
    function [4:0] cls_of;
        input [63:0] v;
        begin
            if (v[62:52] == 11'h7FF) begin
                cls_of = (v[51:0] != 52'h0) ? `FPX_RC_QNAN : (v[63] ? `FPX_RC_NINF : `FPX_RC_PINF);
            end else if (v[62:52] == 11'h000) begin
                if (v[51:0] == 52'h0) begin
                    cls_of = v[63] ? `FPX_RC_NZERO : `FPX_RC_PZERO;
                end else begin
                    cls_of = v[63] ? `FPX_RC_NDEN : `FPX_RC_PDEN;
                end
            end else begin
                cls_of = v[63] ? `FPX_RC_NNORM : `FPX_RC_PNORM;
            end
        end
    endfunction

    // Operand decoding
    wire op = I_OP_VALID;
    wire [3:0] oc = I_OP_CODE;
    wire a_nan = (I_A_CLASS == `FPX_OC_QNAN) || (I_A_CLASS == `FPX_OC_SNAN);
    wire b_nan = (I_B_CLASS == `FPX_OC_QNAN) || (I_B_CLASS == `FPX_OC_SNAN);
    wire a_inf = I_A_CLASS == `FPX_OC_INF;
    wire b_inf = I_B_CLASS == `FPX_OC_INF;
    wire a_zero = I_A_CLASS == `FPX_OC_ZERO;
    wire b_zero = I_B_CLASS == `FPX_OC_ZERO;
    wire a_fin = (I_A_CLASS == `FPX_OC_NORM) || (I_A_CLASS == `FPX_OC_DEN);
    wire is_cmp = (oc == `FPX_OP_CMPU) || (oc == `FPX_OP_CMPO);
    // Operand A only takes part in two-operand operations
    wire is_bin = (oc <= `FPX_OP_DIV) || is_cmp;
    wire is_cvt = (oc == `FPX_OP_CVT64) || (oc == `FPX_OP_CVT32);
    wire is_est = (oc == `FPX_OP_RE) || (oc == `FPX_OP_RSQRTE);
    // Round to single always works in single precision
    wire sp = I_OP_SP || (oc == `FPX_OP_RSP);

    // Invalid operation causes
    wire c_snan = (I_B_CLASS == `FPX_OC_SNAN) || (is_bin && I_A_CLASS == `FPX_OC_SNAN);
    wire c_isi = (oc == `FPX_OP_ADD || oc == `FPX_OP_SUB) && a_inf && b_inf &&
                 (I_A_SIGN ^ I_B_SIGN ^ (oc == `FPX_OP_SUB));
    wire c_idi = (oc == `FPX_OP_DIV) && a_inf && b_inf;
    wire c_zdz = (oc == `FPX_OP_DIV) && a_zero && b_zero;
    wire c_imz = (oc == `FPX_OP_MUL) && ((a_inf && b_zero) || (a_zero && b_inf));
    wire c_cmp = (oc == `FPX_OP_CMPO) && (a_nan || b_nan);
    wire c_root = (oc == `FPX_OP_SQRT || oc == `FPX_OP_RSQRTE) && I_B_SIGN && !b_zero && !b_nan;
    wire c_cvi = is_cvt && (b_inf || b_nan || I_CVT_BIG);
    wire [8:0] inv_vec = {c_cvi, c_root, 1'b0, c_cmp, c_imz, c_zdz, c_idi, c_isi, c_snan};
    wire inv = |inv_vec;

    // Zero divide: finite nonzero over zero, or an estimate of zero
    wire zdiv = ((oc == `FPX_OP_DIV) && b_zero && a_fin) || (is_est && b_zero);

    // Overflow on the rounded exponent, tininess on the unrounded one
    wire [13:0] emax = sp ? `FPX_EMAX_SP : `FPX_EMAX_DP;
    wire [13:0] emin = sp ? `FPX_EMIN_SP : `FPX_EMIN_DP;
    wire [13:0] adj = sp ? `FPX_ADJ_SP : `FPX_ADJ_DP;
    wire ovf = !I_PASS && !I_RND_ZERO && ($signed(I_RND_EXP) > $signed(emax));
    wire tiny = !I_PASS && !I_PRE_ZERO && ($signed(I_PRE_EXP) < $signed(emin));

    // Enables as currently held
    wire ve = st_q[`FPX_B_VE];
    wire oe = st_q[`FPX_B_OE];
    wire ue = st_q[`FPX_B_UE];
    wire ze = st_q[`FPX_B_ZE];
    wire xe = st_q[`FPX_B_XE];
    wire [1:0] rsel = st_q[`FPX_F_RSEL];

    // Outcome of the completing operation
    reg we_c;
    reg [63:0] res_c;
    reg [12:0] set_c;
    reg frfi_c;
    reg fr_c;
    reg fi_c;
    reg cls_c;
    reg cc_c;
    reg [3:0] ccv_c;
    reg [62:0] maxf;

    // Pick the result word and the status updates for one operation
    always @* begin
        we_c = 1'b0;
        res_c = 64'h0;
        set_c = 13'h0;
        frfi_c = 1'b0;
        fr_c = 1'b0;
        fi_c = 1'b0;
        cls_c = 1'b0;
        cc_c = 1'b0;
        ccv_c = I_CMP_CC;
        maxf = sp ? `FPX_MAXF_SP : `FPX_MAXF_DP;
        if (is_cmp) begin
            // Compare never writes the target nor touches the rounding bits
            set_c[8:0] = inv_vec;
            cc_c = 1'b1;
            if (a_nan || b_nan) begin
                ccv_c = `FPX_CC_UNORD;
            end
        end else if (inv) begin
            set_c[8:0] = inv_vec;
            frfi_c = 1'b1;
            if (ve) begin
                // Target and class stay as they were so no operand is lost
                we_c = 1'b0;
            end else if (oc == `FPX_OP_CVT64) begin
                we_c = 1'b1;
                res_c = (!I_B_SIGN && !b_nan) ? `FPX_I64_MAX : `FPX_I64_MIN;
            end else if (oc == `FPX_OP_CVT32) begin
                // Upper word is left undefined; it is written as zero
                we_c = 1'b1;
                res_c = (!I_B_SIGN && !b_nan) ? `FPX_I32_MAX : `FPX_I32_MIN;
            end else begin
                we_c = 1'b1;
                res_c = `FPX_QNAN;
                cls_c = 1'b1;
            end
        end else if (zdiv) begin
            set_c[`FPX_B_ZX] = 1'b1;
            frfi_c = 1'b1;
            if (!ze) begin
                we_c = 1'b1;
                res_c = {(is_est ? 1'b0 : I_A_SIGN) ^ I_B_SIGN, `FPX_INF};
                cls_c = 1'b1;
            end
        end else if (is_cvt) begin
            // Plain conversion: only inexact can arise; class is undefined
            we_c = 1'b1;
            res_c = I_CVT_RESULT;
            set_c[`FPX_B_XX] = I_RND_INX;
            frfi_c = 1'b1;
            fr_c = I_RND_INC;
            fi_c = I_RND_INX;
        end else if (ovf) begin
            set_c[`FPX_B_OX] = 1'b1;
            we_c = 1'b1;
            cls_c = 1'b1;
            frfi_c = 1'b1;
            if (oe) begin
                // Wrapped exponent lets the handler rebuild the true value
                res_c = pack(I_RND_SIGN, I_RND_EXP - adj, I_RND_FRAC);
                set_c[`FPX_B_XX] = I_RND_SIGDIFF;
                fr_c = I_RND_INC;
                fi_c = I_RND_SIGDIFF;
            end else begin
                set_c[`FPX_B_XX] = 1'b1;
                fi_c = 1'b1;
                case (rsel)
                    `FPX_RS_NEAR: res_c = {I_RND_SIGN, `FPX_INF};
                    `FPX_RS_ZERO: res_c = {I_RND_SIGN, maxf};
                    `FPX_RS_PINF: res_c = I_RND_SIGN ? {1'b1, maxf} : {1'b0, `FPX_INF};
                    default: res_c = I_RND_SIGN ? {1'b1, `FPX_INF} : {1'b0, maxf};
                endcase
            end
        end else if (tiny) begin
            we_c = 1'b1;
            cls_c = 1'b1;
            frfi_c = 1'b1;
            if (ue) begin
                // Tininess alone raises underflow when it traps
                set_c[`FPX_B_UX] = 1'b1;
                res_c = pack(I_RND_SIGN, I_RND_EXP + adj, I_RND_FRAC);
                set_c[`FPX_B_XX] = I_RND_SIGDIFF;
                fr_c = I_RND_INC;
                fi_c = I_RND_SIGDIFF;
            end else begin
                res_c = I_ALT_RESULT;
                set_c[`FPX_B_UX] = I_DEN_LOSS;
                set_c[`FPX_B_XX] = I_DEN_LOSS;
                fr_c = I_DEN_INC;
                fi_c = I_DEN_LOSS;
            end
        end else begin
            // Ordinary result, or a special-operand result passed through
            we_c = 1'b1;
            cls_c = 1'b1;
            frfi_c = 1'b1;
            if (I_PASS) begin
                res_c = I_ALT_RESULT;
            end else if (I_RND_ZERO) begin
                res_c = {I_RND_SIGN, 63'h0};
            end else begin
                res_c = pack(I_RND_SIGN, I_RND_EXP, I_RND_FRAC);
            end
            set_c[`FPX_B_XX] = I_RND_INX;
            fr_c = I_RND_INC;
            fi_c = I_RND_INX;
        end
    end

    // Any exception of the operation whose enable is set
    wire op_enx = op && (((|set_c[8:0]) && ve) || (set_c[`FPX_B_ZX] && ze) ||
                  (set_c[`FPX_B_OX] && oe) || (set_c[`FPX_B_UX] && ue) || (set_c[`FPX_B_XX] && xe));

    // APB decode; registers answer with no wait state
    wire acc = I_PSEL && I_PENABLE;
    wire hit_st = I_PADDR == `FPX_OFS_STATUS;
    wire hit_md = I_PADDR == `FPX_OFS_MODE;
    wire st_wr = acc && I_PWRITE && hit_st;
    wire md_wr = acc && I_PWRITE && hit_md;
    assign O_PREADY = 1'b1;
    // Unmapped addresses complete with an error and have no effect
    assign O_PSLVERR = acc && !hit_st && !hit_md;

    // Value software writes to the status register
    wire [31:0] wv = I_PWDATA & `FPX_ST_MASK;
    // A write that sets the software-defined invalid cause is itself an invalid exception
    wire soft_inv = st_wr && wv[`FPX_B_SOFT] && !st_q[`FPX_B_SOFT];
    // A write leaving a flag and its enable both set is an enabled exception
    wire sw_enx = st_wr && (((|wv[8:0]) && wv[`FPX_B_VE]) || (wv[`FPX_B_ZX] && wv[`FPX_B_ZE]) ||
                  (wv[`FPX_B_OX] && wv[`FPX_B_OE]) || (wv[`FPX_B_UX] && wv[`FPX_B_UE]) ||
                  (wv[`FPX_B_XX] && wv[`FPX_B_XE]));

    // Status register next value: software write first, hardware on top
    reg [31:0] st_d;
    always @* begin
        st_d = st_wr ? wv : st_q;
        if (op) begin
            // Hardware sets win over a clear in the same cycle
            st_d[12:0] = st_d[12:0] | set_c;
            if (frfi_c) begin
                st_d[`FPX_B_FR] = fr_c;
                st_d[`FPX_B_FI] = fi_c;
            end
            if (cls_c) begin
                st_d[`FPX_F_CLS] = cls_of(res_c);
            end
            if (cc_c) begin
                st_d[`FPX_F_CC] = ccv_c;
            end
        end
    end

    // Register update and read data capture in the setup phase
    always @(posedge I_REF_CLK) begin
        if (I_RST) begin
            st_q <= `FPX_ST_RESET;
            mode_q <= `FPX_MODE_RESET;
            O_PRDATA <= 32'h0;
        end else begin
            st_q <= st_d;
            if (md_wr) begin
                mode_q <= I_PWDATA[1:0];
            end
            if (I_PSEL && !I_PENABLE) begin
                if (I_PADDR == `FPX_OFS_STATUS) begin
                    O_PRDATA <= st_q;
                end else if (I_PADDR == `FPX_OFS_MODE) begin
                    O_PRDATA <= {30'h0, mode_q};
                end else begin
                    O_PRDATA <= 32'h0;
                end
            end
        end
    end

    // Result and handler request toward completion, one cycle after the operation
    always @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_DONE <= 1'b0;
            O_RES_WE <= 1'b0;
            O_RES_DATA <= 64'h0;
            O_TRAP <= 1'b0;
        end else begin
            O_DONE <= op;
            O_RES_WE <= op && we_c;
            if (op && we_c) begin
                O_RES_DATA <= res_c;
            end
            // Every nonzero mode is handled as precise at the excepting step
            O_TRAP <= (mode_q != 2'h0) && (op_enx || sw_enx || (soft_inv && wv[`FPX_B_VE]));
        end
    end

endmodule

// >>> include/fpx_defs.vh
// Constants for the floating-point exception unit: register offsets, field
// positions, reset values, operation codes and operand and result class codes.
// Assumes it is included by its bare name from the design file.
`ifndef FPX_DEFS_VH
`define FPX_DEFS_VH

// Register byte offsets on the APB
`define FPX_OFS_STATUS 12'h000
`define FPX_OFS_MODE 12'h004

// Status and control register: sticky cause flags
`define FPX_B_SNAN 0
`define FPX_B_ISI 1
`define FPX_B_IDI 2
`define FPX_B_ZDZ 3
`define FPX_B_IMZ 4
`define FPX_B_CMP 5
`define FPX_B_SOFT 6
`define FPX_B_ROOT 7
`define FPX_B_CVI 8
`define FPX_B_ZX 9
`define FPX_B_OX 10
`define FPX_B_UX 11
`define FPX_B_XX 12
// Trap enables
`define FPX_B_VE 16
`define FPX_B_OE 17
`define FPX_B_UE 18
`define FPX_B_ZE 19
`define FPX_B_XE 20
// Rounding select, rounding status, result class field, compare code
`define FPX_F_RSEL 22:21
`define FPX_B_FR 23
`define FPX_B_FI 24
`define FPX_F_CLS 29:25
`define FPX_F_CC 29:26
`define FPX_ST_MASK 32'h3FFF_1FFF
`define FPX_ST_RESET 32'h0000_0000
`define FPX_MODE_RESET 2'h0

// Rounding select codes
`define FPX_RS_NEAR 2'h0
`define FPX_RS_ZERO 2'h1
`define FPX_RS_PINF 2'h2
`define FPX_RS_MINF 2'h3

// Operation codes from the pipeline
`define FPX_OP_ADD 4'h0
`define FPX_OP_SUB 4'h1
`define FPX_OP_MUL 4'h2
`define FPX_OP_DIV 4'h3
`define FPX_OP_SQRT 4'h4
`define FPX_OP_RE 4'h5
`define FPX_OP_RSQRTE 4'h6
`define FPX_OP_RSP 4'h7
`define FPX_OP_RINT 4'h8
`define FPX_OP_CVT64 4'h9
`define FPX_OP_CVT32 4'hA
`define FPX_OP_CMPU 4'hB
`define FPX_OP_CMPO 4'hC

// Operand class codes
`define FPX_OC_ZERO 3'h0
`define FPX_OC_NORM 3'h1
`define FPX_OC_DEN 3'h2
`define FPX_OC_INF 3'h3
`define FPX_OC_QNAN 3'h4
`define FPX_OC_SNAN 3'h5

// Result class field codes (class bit then four condition bits)
`define FPX_RC_QNAN 5'h11
`define FPX_RC_NINF 5'h09
`define FPX_RC_NNORM 5'h08
`define FPX_RC_NDEN 5'h18
`define FPX_RC_NZERO 5'h12
`define FPX_RC_PZERO 5'h02
`define FPX_RC_PDEN 5'h14
`define FPX_RC_PNORM 5'h04
`define FPX_RC_PINF 5'h05
`define FPX_CC_UNORD 4'h1

// Exponent figures and trap-enabled adjust amounts
`define FPX_BIAS 14'd1023
`define FPX_EMAX_DP 14'd1023
`define FPX_EMAX_SP 14'd127
`define FPX_EMIN_DP 14'h3C02
`define FPX_EMIN_SP 14'h3F82
`define FPX_ADJ_DP 14'd1536
`define FPX_ADJ_SP 14'd192

// Special result words in double format, then integer convert limits
`define FPX_QNAN 64'h7FF8_0000_0000_0000
`define FPX_MAXF_DP 63'h7FEF_FFFF_FFFF_FFFF
`define FPX_MAXF_SP 63'h47EF_FFFF_E000_0000
`define FPX_INF 63'h7FF0_0000_0000_0000
`define FPX_I64_MAX 64'h7FFF_FFFF_FFFF_FFFF
`define FPX_I64_MIN 64'h8000_0000_0000_0000
`define FPX_I32_MAX 64'h0000_0000_7FFF_FFFF
`define FPX_I32_MIN 64'h0000_0000_8000_0000

`endif

// >>> testbench/fpx_exception_unit_assertions.sv
// Checker for the exception unit: result, trap and completion relations.
// Assumes it is bound to fpx_exception_unit and sees only its ports.
`include "fpx_defs.vh"
module fpx_chk #(
    parameter AW = 12
) (
    input wire I_REF_CLK,
    input wire I_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [AW-1:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire I_OP_VALID,
    input wire [3:0] I_OP_CODE,
    input wire I_OP_SP,
    input wire [2:0] I_A_CLASS,
    input wire I_A_SIGN,
    input wire [2:0] I_B_CLASS,
    input wire I_B_SIGN,
    input wire [13:0] I_RND_EXP,
    input wire I_RND_SIGN,
    input wire I_PASS,
    input wire O_DONE,
    input wire O_RES_WE,
    input wire [63:0] O_RES_DATA,
    input wire O_TRAP
);
    timeunit 1ns;
    timeprecision 100ps;
    // All checks run on the core clock and sleep through reset
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    // Shadow copies of the enables, so that checks see pre-write values
    reg ve_q;
    reg ze_q;
    reg oe_q;
    reg [1:0] rs_q;
    reg [1:0] md_q;
    reg sx_q;
    wire wr = I_PSEL && I_PENABLE && I_PWRITE;
    wire wr_st = wr && I_PADDR == `FPX_OFS_STATUS;
    wire div0 = I_OP_CODE == `FPX_OP_DIV && I_A_CLASS == `FPX_OC_NORM && I_B_CLASS == `FPX_OC_ZERO;
    // Operand A only counts for two-operand arithmetic; a unary op ignores it
    wire snan = I_B_CLASS == `FPX_OC_SNAN || (I_OP_CODE <= `FPX_OP_DIV && I_A_CLASS == `FPX_OC_SNAN);
    // Snoop software writes of status and mode
    always @(posedge I_REF_CLK) begin
        sx_q <= I_A_SIGN ^ I_B_SIGN;
        if (I_RST) begin
            ve_q <= 1'b0;
            ze_q <= 1'b0;
            oe_q <= 1'b0;
            rs_q <= 2'h0;
            md_q <= 2'h0;
        end else begin
            if (wr_st) begin
                ve_q <= I_PWDATA[`FPX_B_VE];
                ze_q <= I_PWDATA[`FPX_B_ZE];
                oe_q <= I_PWDATA[`FPX_B_OE];
                rs_q <= I_PWDATA[`FPX_F_RSEL];
            end
            if (wr && I_PADDR == `FPX_OFS_MODE) begin
                md_q <= I_PWDATA[1:0];
            end
        end
    end
    AST_INV_KEEP: assert property (I_OP_VALID && ve_q && snan |=> !O_RES_WE)
        else $error("target written on enabled invalid");
    AST_ZDIV_KEEP: assert property (I_OP_VALID && ze_q && div0 |=> !O_RES_WE)
        else $error("target written on enabled zero divide");
    AST_ZDIV_INF: assert property (I_OP_VALID && !ze_q && div0
        |=> O_RES_WE && O_RES_DATA == {sx_q, `FPX_INF})
        else $error("zero divide result not signed infinity");
    AST_ISI_QNAN: assert property (I_OP_VALID && !ve_q && I_OP_CODE == `FPX_OP_ADD
        && I_A_CLASS == `FPX_OC_INF && I_B_CLASS == `FPX_OC_INF && I_A_SIGN != I_B_SIGN
        |=> O_RES_WE && O_RES_DATA == `FPX_QNAN)
        else $error("inf minus inf did not give quiet NaN");
    AST_CVT_SAT: assert property (I_OP_VALID && !ve_q && I_OP_CODE == `FPX_OP_CVT64
        && I_B_CLASS == `FPX_OC_QNAN |=> O_RES_WE && O_RES_DATA == `FPX_I64_MIN)
        else $error("NaN convert not most negative");
    // Rounded-zero input is not visible here; the bench holds it low
    AST_OVF_NEAR: assert property (I_OP_VALID && !oe_q && rs_q == `FPX_RS_NEAR
        && I_OP_CODE == `FPX_OP_ADD && I_A_CLASS == `FPX_OC_NORM && I_B_CLASS == `FPX_OC_NORM
        && !I_PASS && !I_OP_SP && !I_RND_SIGN && $signed(I_RND_EXP) > 1023 |=> O_RES_DATA == {1'b0, `FPX_INF})
        else $error("nearest overflow not infinity");
    AST_TRAP_SRC: assert property (O_TRAP
        |-> $past(md_q) != 2'h0 && ($past(I_OP_VALID) || $past(wr_st)))
        else $error("trap without cause or in ignore mode");
    AST_ZDIV_TRAP: assert property (I_OP_VALID && ze_q && md_q != 2'h0 && div0 |=> O_TRAP)
        else $error("enabled zero divide did not trap");
    AST_WE_SRC: assert property (O_RES_WE |-> $past(I_OP_VALID) && O_DONE)
        else $error("target write without completing operation");
endmodule
bind fpx_exception_unit fpx_chk #(.AW(AW)) i_fpx_chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_OP_VALID(I_OP_VALID),
    .I_OP_CODE(I_OP_CODE), .I_OP_SP(I_OP_SP), .I_A_CLASS(I_A_CLASS), .I_A_SIGN(I_A_SIGN), .I_B_CLASS(I_B_CLASS),
    .I_B_SIGN(I_B_SIGN), .I_RND_EXP(I_RND_EXP), .I_RND_SIGN(I_RND_SIGN), .I_PASS(I_PASS), .O_DONE(O_DONE),
    .O_RES_WE(O_RES_WE), .O_RES_DATA(O_RES_DATA), .O_TRAP(O_TRAP));

// >>> testbench/fpx_pipe_model.sv
// Pipeline model: turns a bench request into a one-cycle completing operation.
// Assumes requests are raised for one cycle at a time by the bench.
module fpx_pipe_model (
    input wire i_clk,
    input wire i_rst,
    input wire i_req,
    input wire [13:0] i_op,
    output reg o_valid,
    output reg [13:0] o_op
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle fields toggle, so the unit cannot lean on stale operands
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_op <= 14'h0000;
        end else begin
            o_valid <= i_req;
            o_op <= i_req ? i_op : ~o_op;
        end
    end
endmodule

// >>> testbench/fp_exception_handling_bench.sv
// Self-checking bench for the exception unit: APB access and operations.
// Assumes the pipeline model and the bound checker are compiled alongside.
`include "fpx_defs.vh"
module fp_exception_handling_bench;
    timeunit 1ns;
    timeprecision 100ps;
    reg clk, rst, psel, pen, pwr, req, rsgn, inc, sig, dinc, dloss, inx;
    reg [11:0] paddr;
    reg [31:0] pwdata;
    reg [13:0] rop, rexp;
    reg [51:0] frac;
    reg [63:0] alt, cvt;
    reg [3:0] cc;
    wire [31:0] prdata;
    wire pready, pslverr, vld, done, we, trap;
    wire [13:0] op;
    wire [63:0] rdata;
    logic [66:0] expq[$]; // Expected {done, write, trap, data}
    integer seed, miscompares, n_compared, i;
    reg inf_r;
    reg [4:0] cls;
    fpx_pipe_model i_fpx_pipe_model (.i_clk(clk), .i_rst(rst), .i_req(req), .i_op(rop), .o_valid(vld), .o_op(op));
    fpx_exception_unit i_fpx_exception_unit (.I_REF_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_OP_VALID(vld), .I_OP_CODE(op[13:10]), .I_OP_SP(op[9]), .I_A_CLASS(op[8:6]),
        .I_A_SIGN(op[5]), .I_B_CLASS(op[4:2]), .I_B_SIGN(op[1]), .I_CVT_BIG(op[0]), .I_PRE_EXP(rexp),
        .I_PRE_ZERO(1'b0), .I_RND_SIGN(rsgn), .I_RND_EXP(rexp), .I_RND_FRAC(frac), .I_RND_ZERO(1'b0),
        .I_RND_INC(inc), .I_RND_INX(inx), .I_RND_SIGDIFF(sig), .I_PASS(1'b0), .I_ALT_RESULT(alt),
        .I_DEN_INC(dinc), .I_DEN_LOSS(dloss), .I_CVT_RESULT(cvt), .I_CMP_CC(cc), .O_DONE(done),
        .O_RES_WE(we), .O_RES_DATA(rdata), .O_TRAP(trap));
    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task cmp(input [66:0] e, input [66:0] g);
        n_compared = n_compared + 1;
        if (e !== g) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Oldest note against each completion or trap pulse
    task chk_op(input [66:0] g);
        cmp(expq.size() > 0 ? expq.pop_front() : ~g, g);
    endtask
    always @(posedge clk) begin
        if (done === 1'b1 || trap === 1'b1) begin
            chk_op({done, we, trap, we === 1'b1 ? rdata : 64'h0});
        end
    end
    // One APB transfer; the answer is taken at the edge that sees pready
    task acc(input w, input [11:0] a, input [31:0] d, input [32:0] e);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        cmp({34'h0, e}, {34'h0, pslverr, w ? 32'h0 : prdata});
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Issue one operation with fresh random datapath side values
    task opr(input [3:0] c, input [2:0] ac, input as, input [2:0] bc, input bs, input [13:0] x, input [66:0] e);
        integer r;
        r = $random(seed);
        @(posedge clk);
        req <= 1'b1;
        rop <= {c, 1'b0, ac, as, bc, bs, 1'b0};
        rexp <= x;
        rsgn <= as;
        frac <= {r[19:0], r};
        alt <= {r, ~r};
        cvt <= {~r, r};
        cc <= r[3:0];
        {inc, sig, dinc, dloss, inx} <= r[8:4];
        expq.push_back(e);
        @(posedge clk);
        req <= 1'b0;
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hang guard, far beyond the roughly 125 cycles the run needs
    initial begin
        #50000;
        miscompares = miscompares + 1;
        give_verdict;
    end
    initial begin
        {psel, pen, pwr, req, rsgn, inc, sig, dinc, dloss, inx} = 10'h000;
        {paddr, pwdata, rop, rexp, frac, alt, cvt, cc} = 0;
        seed = 28;
        miscompares = 0;
        n_compared = 0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        acc(0, `FPX_OFS_MODE, 0, 33'h0);
        acc(1, 12'h008, 32'hFFFF_FFFF, {1'b1, 32'h0});
        acc(0, `FPX_OFS_STATUS, 0, {1'b0, `FPX_ST_RESET});
        // Disabled invalid, then disabled zero divide on top of it
        opr(`FPX_OP_ADD, `FPX_OC_INF, 0, `FPX_OC_INF, 1, 0, {3'b110, `FPX_QNAN});
        acc(0, `FPX_OFS_STATUS, 0, 33'h0_2200_0002);
        opr(`FPX_OP_DIV, `FPX_OC_NORM, 1, `FPX_OC_ZERO, 0, 0, {3'b110, 1'b1, `FPX_INF});
        acc(0, `FPX_OFS_STATUS, 0, 33'h0_1200_0202);
        // Enabled invalid and zero divide in precise mode trap and keep target
        acc(1, `FPX_OFS_MODE, 32'h3, 33'h0);
        acc(1, `FPX_OFS_STATUS, 32'h0009_0000, 33'h0);
        opr(`FPX_OP_DIV, `FPX_OC_ZERO, 0, `FPX_OC_ZERO, 0, 0, {3'b101, 64'h0});
        opr(`FPX_OP_DIV, `FPX_OC_NORM, 0, `FPX_OC_ZERO, 1, 0, {3'b101, 64'h0});
        opr(`FPX_OP_ADD, `FPX_OC_SNAN, 0, `FPX_OC_NORM, 0, 0, {3'b101, 64'h0});
        acc(0, `FPX_OFS_STATUS, 0, 33'h0_0009_0209);
        // Software sets the soft flag with invalid enabled
        expq.push_back({3'b001, 64'h0});
        acc(1, `FPX_OFS_STATUS, 32'h0001_0040, 33'h0);
        acc(1, `FPX_OFS_STATUS, 0, 33'h0);
        acc(1, `FPX_OFS_MODE, 0, 33'h0);
        // Saturating converts, a zero estimate and a NaN compare accumulate flags
        opr(`FPX_OP_CVT64, 0, 0, `FPX_OC_QNAN, 0, 0, {3'b110, `FPX_I64_MIN});
        opr(`FPX_OP_CVT32, 0, 0, `FPX_OC_INF, 0, 0, {3'b110, `FPX_I32_MAX});
        // The compare code then overwrites the upper class bits the estimate left
        opr(`FPX_OP_RE, 0, 0, `FPX_OC_ZERO, 1, 0, {3'b110, 1'b1, `FPX_INF});
        opr(`FPX_OP_CMPO, `FPX_OC_QNAN, 0, `FPX_OC_NORM, 0, 0, {3'b100, 64'h0});
        acc(0, `FPX_OFS_STATUS, 0, 33'h0_0600_0320);
        // Disabled overflow in each rounding mode and sign
        for (i = 0; i < 8; i = i + 1) begin
            inf_r = i[1:0] == 0 || (i[1:0] == 2 && !i[2]) || (i[1:0] == 3 && i[2]);
            cls = inf_r ? (i[2] ? `FPX_RC_NINF : `FPX_RC_PINF) : (i[2] ? `FPX_RC_NNORM : `FPX_RC_PNORM);
            acc(1, `FPX_OFS_STATUS, {9'h0, i[1:0], 21'h0}, 33'h0);
            opr(`FPX_OP_ADD, `FPX_OC_NORM, i[2], `FPX_OC_NORM, i[2], 14'd1100,
                {3'b110, i[2], inf_r ? `FPX_INF : `FPX_MAXF_DP});
            acc(0, `FPX_OFS_STATUS, 0, {3'b000, cls, 1'b1, 1'b0, i[1:0], 8'h0, 13'h1400});
        end
        repeat (4) @(posedge clk);
        if (expq.size() != 0) miscompares = miscompares + 1;
        give_verdict;
    end
endmodule
